// [rtl/pwmaux_params.svh]
// Register offsets, field positions and timing counts of the power stage aux unit
//
// Contract
// - Mode 14 retrigger edge never changes the output period or frequency.
// - Mode 14 holds the output inactive while input active; ramp continues. Matrix-driven outputs keep the matrix value.
// - First revision: mode 14 event counts only inside on-time; else outputs stay.
// - A retrigger or fault event latches the counter into the capture register.
// - Each new capture overwrites the capture register, read or not.
// - Four-ramp matrix drives outputs 0 and 1 with a programmed value per ramp.
// - Polarity setting is ignored for matrix-driven outputs.
// - Extra output A copies output 0, or output 1 when its selector is set.
// - Extra output B copies output 1, or output 0 when its selector is set.
// - ADC sync pulse on chosen rising or falling edge of output 0 or 1.
// - Centered mode uses reset-A compare as ADC sync point, programmed at least 1.
// - Interrupt sources: counter reload, input event, mutual synchronization error.
// - Two requests: end-of-cycle on reset-B match; capture on event or sync error.
// - Chained units align: centered on center, ramp modes on edges.
// - Auto-run unit starts together with previous unit in the chain.
// - Passed run signal deasserting stops the following unit.
// - Only mode 7 halt faults travel the chain; slave forwards them backward.
// - Clock-select bit picks PLL clock when set, I/O clock when clear.
// - Two-bit prescaler divides by 1,4,16,64 or, later revision, 1,4,32,256.
// - Sync source: 00 lead out0, 01 trail out0, 10 lead out1, 11 trail out1.
`ifndef PWMAUX_PARAMS_SVH
`define PWMAUX_PARAMS_SVH

// Byte offsets
`define PWMAUX_ADR_CTRL   8'h00
`define PWMAUX_ADR_CONF   8'h04
`define PWMAUX_ADR_SYNC   8'h08
`define PWMAUX_ADR_RA     8'h0C
`define PWMAUX_ADR_RB     8'h10
`define PWMAUX_ADR_MAT    8'h14
`define PWMAUX_ADR_CAPT   8'h18
`define PWMAUX_ADR_MASK   8'h1C
`define PWMAUX_ADR_FLAG   8'h20

// Control fields
`define PWMAUX_CTRL_RUN   0
`define PWMAUX_CTRL_ARUN  1
`define PWMAUX_CTRL_PRE0  2
`define PWMAUX_CTRL_PRE1  3
// Configuration fields
`define PWMAUX_CONF_CLK   0
`define PWMAUX_CONF_MOD0  1
`define PWMAUX_CONF_MOD1  2
`define PWMAUX_CONF_POL   3
`define PWMAUX_CONF_MATX  4
`define PWMAUX_CONF_LVL   5
`define PWMAUX_CONF_IM0   8
`define PWMAUX_CONF_IM3   11
// Sync/output fields
`define PWMAUX_SYNC_EN0   0
`define PWMAUX_SYNC_ENA   1
`define PWMAUX_SYNC_EN1   2
`define PWMAUX_SYNC_ENB   3
`define PWMAUX_SYNC_SRC0  4
`define PWMAUX_SYNC_SRC1  5
`define PWMAUX_SYNC_SELA  6
`define PWMAUX_SYNC_SELB  7
// Flag and mask fields
`define PWMAUX_IRQ_EC     0
`define PWMAUX_IRQ_CAPT   1

// Prescaler terminal counts (divisor minus one)
`define PWMAUX_PRE_DIV1   8'h00
`define PWMAUX_PRE_DIV4   8'h03
`define PWMAUX_PRE_DIV16  8'h0F
`define PWMAUX_PRE_DIV64  8'h3F
`define PWMAUX_PRE_DIV32  8'h1F
`define PWMAUX_PRE_DIV256 8'hFF

`define PWMAUX_RA_MIN     12'h001

`endif

// [rtl/pwmaux_pkg.sv]
// Shared types of the power stage aux unit
`default_nettype none
package pwmaux_pkg;
  typedef enum logic [1:0] {
    PWMAUX_ONE_RAMP  = 2'b00,
    PWMAUX_TWO_RAMP  = 2'b01,
    PWMAUX_FOUR_RAMP = 2'b10,
    PWMAUX_CENTERED  = 2'b11
  } pwmaux_run_mode_e;

  typedef enum logic [3:0] {
    PWMAUX_IM_NONE  = 4'h0,
    PWMAUX_IM_HALT  = 4'h7,
    PWMAUX_IM_BLANK = 4'hE
  } pwmaux_in_mode_e;
endpackage
`default_nettype wire

// [rtl/pwmaux_top.sv]
// Power stage unit aux logic: blanking, capture, matrix, ADC sync, irq, run chain
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`include "pwmaux_params.svh"
`default_nettype none
module pwmaux_top #(
  parameter logic REV_LATER = 1'b0
) (
  // Clock and reset
  input  wire  logic        MCLK_I,
  input  wire  logic        RST_N_I,
  // Wishbone slave
  input  wire  logic        WB_CYC_I,
  input  wire  logic        WB_STB_I,
  input  wire  logic        WB_WE_I,
  input  wire  logic [7:0]  WB_ADR_I,
  input  wire  logic [3:0]  WB_SEL_I,
  input  wire  logic [31:0] WB_DAT_I,
  output var   logic [31:0] WB_DAT_O,
  output var   logic        WB_ACK_O,
  // Clock source strobes
  input  wire  logic        PLL_TICK_I,
  input  wire  logic        IO_TICK_I,
  // Retrigger/fault pin
  input  wire  logic        RETRIG_I,
  // Run daisy-chain
  input  wire  logic        RUN_PREV_I,
  input  wire  logic        CYCLE_PREV_I,
  input  wire  logic        FAULT_NEXT_I,
  output logic              RUN_NEXT_O,
  output var   logic        CYCLE_END_O,
  output var   logic        FAULT_PREV_O,
  // Waveform outputs
  output var   logic        WAVE_OUT0_O,
  output var   logic        WAVE_OUT1_O,
  output var   logic        EXTRA_WAVE_OUT_A_O,
  output var   logic        EXTRA_WAVE_OUT_B_O,
  output var   logic        ADC_SYNC_O,
  // Interrupt requests
  output logic              END_CYCLE_IRQ_O,
  output logic              CAPTURE_IRQ_O
);
  // ****************************************************
  // Registers and bus
  // ****************************************************
  logic [3:0]  ctrl_q;
  logic [11:0] conf_q;
  logic [7:0]  sync_q;
  logic [11:0] reset_a_compare_q;
  logic [11:0] reset_b_compare_q;
  logic [7:0]  matrix_q;
  logic [11:0] counter_capture_value_q;
  logic [1:0]  mask_q;
  logic [1:0]  flag_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        wr_en;
  logic [31:0] bmask;
  logic [31:0] wnew;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] m);
    merge = (old_v & ~m) | (WB_DAT_I & m);
  endfunction

  assign bmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign wr_en = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_q;
  assign wnew  = merge(32'h0000_0000, bmask);
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= WB_CYC_I && WB_STB_I && !ack_q;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      rdat_q <= 32'h0000_0000;
    end else if (WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_q) begin
      if (WB_ADR_I == `PWMAUX_ADR_CTRL) begin
        rdat_q <= {28'h000_0000, ctrl_q};
      end else if (WB_ADR_I == `PWMAUX_ADR_CONF) begin
        rdat_q <= {20'h0_0000, conf_q};
      end else if (WB_ADR_I == `PWMAUX_ADR_SYNC) begin
        rdat_q <= {24'h00_0000, sync_q};
      end else if (WB_ADR_I == `PWMAUX_ADR_RA) begin
        rdat_q <= {20'h0_0000, reset_a_compare_q};
      end else if (WB_ADR_I == `PWMAUX_ADR_RB) begin
        rdat_q <= {20'h0_0000, reset_b_compare_q};
      end else if (WB_ADR_I == `PWMAUX_ADR_MAT) begin
        rdat_q <= {24'h00_0000, matrix_q};
      end else if (WB_ADR_I == `PWMAUX_ADR_CAPT) begin
        rdat_q <= {20'h0_0000, counter_capture_value_q};
      end else if (WB_ADR_I == `PWMAUX_ADR_MASK) begin
        rdat_q <= {30'h0000_0000, mask_q};
      end else if (WB_ADR_I == `PWMAUX_ADR_FLAG) begin
        rdat_q <= {30'h0000_0000, flag_q};
      end else begin
        rdat_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      conf_q            <= 12'h000;
      sync_q            <= 8'h00;
      reset_a_compare_q <= `PWMAUX_RA_MIN;
      reset_b_compare_q <= 12'h000;
      matrix_q          <= 8'h00;
      mask_q            <= 2'h0;
    end else if (wr_en) begin
      if (WB_ADR_I == `PWMAUX_ADR_CONF) begin
        conf_q <= 12'(merge({20'h0_0000, conf_q}, bmask));
      end else if (WB_ADR_I == `PWMAUX_ADR_SYNC) begin
        sync_q <= 8'(merge({24'h00_0000, sync_q}, bmask));
      end else if (WB_ADR_I == `PWMAUX_ADR_RA) begin
        reset_a_compare_q <= 12'(merge({20'h0_0000, reset_a_compare_q}, bmask));
      end else if (WB_ADR_I == `PWMAUX_ADR_RB) begin
        reset_b_compare_q <= 12'(merge({20'h0_0000, reset_b_compare_q}, bmask));
      end else if (WB_ADR_I == `PWMAUX_ADR_MAT) begin
        matrix_q <= 8'(merge({24'h00_0000, matrix_q}, bmask));
      end else if (WB_ADR_I == `PWMAUX_ADR_MASK) begin
        mask_q <= 2'(merge({30'h0000_0000, mask_q}, bmask));
      end
    end
  end

  // ****************************************************
  // Mode decode and input conditioning
  // ****************************************************
  pwmaux_pkg::pwmaux_run_mode_e run_mode;
  logic [3:0] in_mode;
  logic       im_valid;
  logic       in_s1_q;
  logic       in_s2_q;
  logic       in_prev_q;
  logic       in_act;
  logic       in_edge;

  assign run_mode = pwmaux_pkg::pwmaux_run_mode_e'(conf_q[`PWMAUX_CONF_MOD1:`PWMAUX_CONF_MOD0]);
  assign in_mode  = conf_q[`PWMAUX_CONF_IM3:`PWMAUX_CONF_IM0];
  // Reserved codes 10..13 and 15 behave as no action
  assign im_valid = (in_mode != 4'hA) && (in_mode != 4'hB) && (in_mode != 4'hC) &&
                    (in_mode != 4'hD) && (in_mode != 4'hF) &&
                    (in_mode != pwmaux_pkg::PWMAUX_IM_NONE);

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      in_s1_q   <= 1'b0;
      in_s2_q   <= 1'b0;
      in_prev_q <= 1'b0;
    end else begin
      in_s1_q   <= RETRIG_I;
      in_s2_q   <= in_s1_q;
      in_prev_q <= in_act;
    end
  end

  assign in_act  = conf_q[`PWMAUX_CONF_LVL] ? in_s2_q : !in_s2_q;
  assign in_edge = in_act && !in_prev_q && im_valid;

  // ****************************************************
  // Clock selection and prescaler
  // ****************************************************
  logic       src_tick;
  logic [7:0] pre_last;
  logic [7:0] pre_cnt_q;
  logic       unit_clock;

  assign src_tick = conf_q[`PWMAUX_CONF_CLK] ? PLL_TICK_I : IO_TICK_I;

  always_comb begin
    case (ctrl_q[`PWMAUX_CTRL_PRE1:`PWMAUX_CTRL_PRE0])
      2'b00:   pre_last = `PWMAUX_PRE_DIV1;
      2'b01:   pre_last = `PWMAUX_PRE_DIV4;
      2'b10:   pre_last = REV_LATER ? `PWMAUX_PRE_DIV32 : `PWMAUX_PRE_DIV16;
      default: pre_last = REV_LATER ? `PWMAUX_PRE_DIV256 : `PWMAUX_PRE_DIV64;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      pre_cnt_q <= 8'h00;
    end else if (src_tick) begin
      pre_cnt_q <= (pre_cnt_q >= pre_last) ? 8'h00 : pre_cnt_q + 8'h01;
    end
  end

  assign unit_clock = src_tick && (pre_cnt_q >= pre_last);

  // ****************************************************
  // Run chain
  // ****************************************************
  logic halt_q;
  logic run_eff;
  logic halt_evt;

  // A halt-type fault here, or one forwarded by the next unit, stops the unit
  assign halt_evt = (in_mode == pwmaux_pkg::PWMAUX_IM_HALT) && (in_edge || FAULT_NEXT_I);
  assign run_eff  = (ctrl_q[`PWMAUX_CTRL_ARUN] ? RUN_PREV_I : ctrl_q[`PWMAUX_CTRL_RUN])
                    && !halt_q;
  // Combinational pass-through so the whole chain starts on one edge
  assign RUN_NEXT_O = run_eff;

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      ctrl_q <= 4'h0;
    end else if (halt_evt) begin
      ctrl_q[`PWMAUX_CTRL_RUN] <= 1'b0;
    end else if (wr_en && WB_ADR_I == `PWMAUX_ADR_CTRL) begin
      ctrl_q <= 4'(merge({28'h000_0000, ctrl_q}, bmask));
    end
  end

  // Slave halt releases when the previous unit's run drops or software sets run
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      halt_q <= 1'b0;
    end else if (halt_evt) begin
      halt_q <= 1'b1;
    end else if ((ctrl_q[`PWMAUX_CTRL_ARUN] && !RUN_PREV_I) ||
                 (wr_en && WB_ADR_I == `PWMAUX_ADR_CTRL && WB_SEL_I[0] &&
                  wnew[`PWMAUX_CTRL_RUN])) begin
      halt_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      FAULT_PREV_O <= 1'b0;
    end else begin
      FAULT_PREV_O <= ctrl_q[`PWMAUX_CTRL_ARUN] && (in_mode == pwmaux_pkg::PWMAUX_IM_HALT) &&
                      in_edge;
    end
  end

  // ****************************************************
  // Counter and ramp sequencing
  // ****************************************************
  logic [11:0] cnt_q;
  logic [1:0]  ramp_q;
  logic        down_q;
  logic        end_evt;

  assign end_evt = run_eff && unit_clock && (cnt_q == reset_b_compare_q);

  // Input events other than a mode 7 halt never touch the counter, so period stays fixed
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I || !run_eff) begin
      cnt_q  <= 12'h000;
      ramp_q <= 2'h0;
      down_q <= 1'b0;
    end else if (unit_clock) begin
      if (run_mode == pwmaux_pkg::PWMAUX_CENTERED) begin
        if (!down_q && cnt_q >= reset_b_compare_q) begin
          down_q <= 1'b1;
          cnt_q  <= cnt_q - 12'h001;
        end else if (down_q && cnt_q == 12'h000) begin
          down_q <= 1'b0;
          cnt_q  <= 12'h001;
        end else begin
          cnt_q  <= down_q ? cnt_q - 12'h001 : cnt_q + 12'h001;
        end
      end else if (cnt_q >= reset_b_compare_q) begin
        cnt_q <= 12'h000;
        if (run_mode == pwmaux_pkg::PWMAUX_TWO_RAMP) begin
          ramp_q <= {1'b0, !ramp_q[0]};
        end else if (run_mode == pwmaux_pkg::PWMAUX_FOUR_RAMP) begin
          ramp_q <= ramp_q + 2'h1;
        end
      end else begin
        cnt_q <= cnt_q + 12'h001;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      CYCLE_END_O <= 1'b0;
    end else begin
      CYCLE_END_O <= end_evt;
    end
  end

  // ****************************************************
  // Waveforms, blanking and output routing
  // ****************************************************
  logic wa_raw;
  logic wb_raw;
  logic wa_prev_q;
  logic wb_prev_q;
  logic blank_q;
  logic blank;
  logic on_time;
  logic matrix_on;
  logic out0_d;
  logic out1_d;

  always_comb begin
    wa_raw = 1'b0;
    wb_raw = 1'b0;
    if (run_eff) begin
      case (run_mode)
        pwmaux_pkg::PWMAUX_ONE_RAMP: begin
          wa_raw = cnt_q < reset_a_compare_q;
          wb_raw = !wa_raw;
        end
        pwmaux_pkg::PWMAUX_CENTERED: begin
          wa_raw = cnt_q < {1'b0, reset_b_compare_q[11:1]};
          wb_raw = !wa_raw;
        end
        default: begin
          wa_raw = !ramp_q[0] && (cnt_q < reset_a_compare_q);
          wb_raw = ramp_q[0] && (cnt_q < reset_a_compare_q);
        end
      endcase
    end
  end

  assign on_time = wa_raw || wb_raw;

  // Outside on-time the first revision drops the edge, leaving outputs active
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I || !in_act) begin
      blank_q <= 1'b0;
    end else if (in_mode == pwmaux_pkg::PWMAUX_IM_BLANK && in_edge &&
                 (REV_LATER || on_time)) begin
      blank_q <= 1'b1;
    end
  end

  assign blank = blank_q || (in_mode == pwmaux_pkg::PWMAUX_IM_BLANK && in_edge &&
                             (REV_LATER || on_time));
  assign matrix_on = conf_q[`PWMAUX_CONF_MATX] &&
                     run_mode == pwmaux_pkg::PWMAUX_FOUR_RAMP && run_eff;

  always_comb begin
    if (matrix_on) begin
      out0_d = matrix_q[{1'b0, ramp_q}];
      out1_d = matrix_q[{1'b1, ramp_q}];
    end else begin
      out0_d = (wa_raw && !blank) ~^ conf_q[`PWMAUX_CONF_POL];
      out1_d = (wb_raw && !blank) ~^ conf_q[`PWMAUX_CONF_POL];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      WAVE_OUT0_O        <= 1'b0;
      WAVE_OUT1_O        <= 1'b0;
      EXTRA_WAVE_OUT_A_O <= 1'b0;
      EXTRA_WAVE_OUT_B_O <= 1'b0;
    end else begin
      WAVE_OUT0_O <= sync_q[`PWMAUX_SYNC_EN0] && out0_d;
      WAVE_OUT1_O <= sync_q[`PWMAUX_SYNC_EN1] && out1_d;
      EXTRA_WAVE_OUT_A_O <= sync_q[`PWMAUX_SYNC_ENA] &&
                            (sync_q[`PWMAUX_SYNC_SELA] ? out1_d : out0_d);
      EXTRA_WAVE_OUT_B_O <= sync_q[`PWMAUX_SYNC_ENB] &&
                            (sync_q[`PWMAUX_SYNC_SELB] ? out0_d : out1_d);
    end
  end

  // ****************************************************
  // ADC synchronization
  // ****************************************************
  logic sync_d;

  always_comb begin
    sync_d = 1'b0;
    if (run_mode == pwmaux_pkg::PWMAUX_CENTERED) begin
      // Reset-A compare is free in this mode and marks the sample point
      if (!sync_q[`PWMAUX_SYNC_SRC1] && unit_clock && run_eff &&
          cnt_q == reset_a_compare_q) begin
        sync_d = sync_q[`PWMAUX_SYNC_SRC0] ? !down_q : down_q;
      end
    end else begin
      case (sync_q[`PWMAUX_SYNC_SRC1:`PWMAUX_SYNC_SRC0])
        2'b00:   sync_d = wa_raw && !wa_prev_q;
        2'b01:   sync_d = !wa_raw && wa_prev_q;
        2'b10:   sync_d = wb_raw && !wb_prev_q;
        default: sync_d = !wb_raw && wb_prev_q;
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      wa_prev_q  <= 1'b0;
      wb_prev_q  <= 1'b0;
      ADC_SYNC_O <= 1'b0;
    end else begin
      wa_prev_q  <= wa_raw;
      wb_prev_q  <= wb_raw;
      ADC_SYNC_O <= sync_d;
    end
  end

  // ****************************************************
  // Capture and interrupt flags
  // ****************************************************
  logic capt_evt;
  logic sync_err;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;

  assign capt_evt = in_edge && run_eff;
  // Slave whose cycle end disagrees with the previous unit's
  assign sync_err = ctrl_q[`PWMAUX_CTRL_ARUN] && run_eff && (CYCLE_PREV_I != CYCLE_END_O);
  assign flag_set = {capt_evt || sync_err, end_evt};
  assign flag_clr = (wr_en && WB_ADR_I == `PWMAUX_ADR_FLAG) ? wnew[1:0] : 2'h0;

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      counter_capture_value_q <= 12'h000;
    end else if (capt_evt) begin
      counter_capture_value_q <= cnt_q;
    end
  end

  // Set beats a clear landing in the same cycle
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      flag_q <= 2'h0;
    end else begin
      flag_q <= flag_set | (flag_q & ~flag_clr);
    end
  end

  assign END_CYCLE_IRQ_O = flag_q[`PWMAUX_IRQ_EC] && mask_q[`PWMAUX_IRQ_EC];
  assign CAPTURE_IRQ_O   = flag_q[`PWMAUX_IRQ_CAPT] && mask_q[`PWMAUX_IRQ_CAPT];

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  freq_kept_a: assert property (
    (run_eff && unit_clock && in_edge && run_mode != pwmaux_pkg::PWMAUX_CENTERED &&
     cnt_q < reset_b_compare_q) ##1 run_eff |-> cnt_q == $past(cnt_q) + 12'h001)
    else $error("Input edge disturbed counter");
  blank_hold_a: assert property (
    (blank && in_act && !matrix_on) |-> ##1 (WAVE_OUT0_O == !conf_q[`PWMAUX_CONF_POL] ||
     !$past(sync_q[`PWMAUX_SYNC_EN0])))
    else $error("Output not blanked");
  rev_ignore_a: assert property (
    (!REV_LATER && in_edge && !on_time && !blank_q) |-> !blank)
    else $error("Edge outside on-time blanked");
  capture_latch_a: assert property (
    capt_evt |=> counter_capture_value_q == $past(cnt_q) && flag_q[`PWMAUX_IRQ_CAPT])
    else $error("Capture missed");
  matrix_drive_a: assert property (
    (matrix_on && sync_q[`PWMAUX_SYNC_EN0]) |=> WAVE_OUT0_O == $past(matrix_q[{1'b0, ramp_q}]))
    else $error("Matrix value wrong");
  extra_sel_a: assert property (
    $past(sync_q[`PWMAUX_SYNC_ENA] && sync_q[`PWMAUX_SYNC_EN0] && sync_q[`PWMAUX_SYNC_EN1] &&
          sync_q[`PWMAUX_SYNC_ENB]) |->
    EXTRA_WAVE_OUT_A_O == ($past(sync_q[`PWMAUX_SYNC_SELA]) ? WAVE_OUT1_O : WAVE_OUT0_O) &&
    EXTRA_WAVE_OUT_B_O == ($past(sync_q[`PWMAUX_SYNC_SELB]) ? WAVE_OUT0_O : WAVE_OUT1_O))
    else $error("Extra output selection wrong");
  adc_lead_a: assert property (
    (run_mode == pwmaux_pkg::PWMAUX_ONE_RAMP && wa_raw && !wa_prev_q &&
     sync_q[`PWMAUX_SYNC_SRC1:`PWMAUX_SYNC_SRC0] == 2'b00)
    |=> ADC_SYNC_O)
    else $error("ADC sync missing");
  chain_stop_a: assert property (
    $fell(run_eff) |-> !RUN_NEXT_O ##1 cnt_q == 12'h000)
    else $error("Stopped unit kept counting");
  auto_start_a: assert property (
    (ctrl_q[`PWMAUX_CTRL_ARUN] && RUN_PREV_I && !halt_q) |-> RUN_NEXT_O)
    else $error("Auto-run unit did not follow");
  fault_fwd_a: assert property (
    (ctrl_q[`PWMAUX_CTRL_ARUN] && in_mode == pwmaux_pkg::PWMAUX_IM_HALT && in_edge) |=>
    FAULT_PREV_O && halt_q)
    else $error("Fault not forwarded");
  pre_bound_a: assert property (
    pre_cnt_q <= (REV_LATER ? `PWMAUX_PRE_DIV256 : `PWMAUX_PRE_DIV64))
    else $error("Prescaler overran");
  ec_irq_a: assert property (
    (end_evt && mask_q[`PWMAUX_IRQ_EC]) |=> END_CYCLE_IRQ_O [*2])
    else $error("End-cycle request not held");

  blank_cov: cover property (in_mode == pwmaux_pkg::PWMAUX_IM_BLANK && blank ##1 !in_act);
  matrix_cov: cover property (matrix_on && ramp_q == 2'h3);
  halt_cov: cover property (halt_evt ##1 halt_q);
endmodule
`default_nettype wire

// [verif/pwm_stage_aux_control_test.sv]
// Self-checking bench for the power stage aux unit
`include "pwmaux_params.svh"
`default_nettype none
module pwm_stage_aux_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Stimulus and state
  // ********************
  logic        clk, rst_n, cyc, stb, we, run_prev, ack, run_nxt, fprev, f, io_t, fnext;
  logic [3:0]  sel;
  logic        w0, w1, wa, wb, adc, eirq, cirq;
  logic [7:0]  adr;
  logic [31:0] dat, rdat, d_o, c1;
  wire  logic  retrig, cend;
  int          miscompares = 0, num_checks = 0, cycles = 0;
  pwmaux_top u_pwmaux_top (.MCLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(d_o),
    .WB_ACK_O(ack), .PLL_TICK_I(1'b1), .IO_TICK_I(io_t), .RETRIG_I(retrig),
    .RUN_PREV_I(run_prev), .CYCLE_PREV_I(1'b0), .FAULT_NEXT_I(fnext), .RUN_NEXT_O(run_nxt),
    .CYCLE_END_O(cend), .FAULT_PREV_O(fprev), .WAVE_OUT0_O(w0), .WAVE_OUT1_O(w1),
    .EXTRA_WAVE_OUT_A_O(wa), .EXTRA_WAVE_OUT_B_O(wb), .ADC_SYNC_O(adc),
    .END_CYCLE_IRQ_O(eirq), .CAPTURE_IRQ_O(cirq));
  pwmaux_stage_model u_pwmaux_stage_model (.clk_i(clk), .adc_sync_i(adc), .retrig_o(retrig));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard: run needs about 6300 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wbc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rdat = d_o;
    {cyc, stb, we} <= 3'b000;
  endtask
  // Lands on the start of an on-time, not on a rise after blanking ends
  task automatic wait_on();
    repeat (2) @(negedge clk);
    while (w0 !== 1'b1) @(negedge clk);
    while (w0 !== 1'b0) @(negedge clk);
    while (w0 !== 1'b1) @(negedge clk);
  endtask
  // Any 512-cycle window of a 256-cycle period holds exactly two pulses
  task automatic adc_win(input int exp);
    int n0;
    repeat (4) @(posedge clk);
    n0 = u_pwmaux_stage_model.adc_cnt;
    repeat (512) @(posedge clk);
    check(u_pwmaux_stage_model.adc_cnt - n0, exp);
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_setup();
    wbc(1'b0, `PWMAUX_ADR_RA, 32'h0);
    check(rdat, 32'h1);
    wbc(1'b0, 8'h3C, 32'h0);
    check(rdat, 32'h0);
    sel <= 4'h2;
    wbc(1'b1, `PWMAUX_ADR_RA, 32'hFFFF_FFFF);
    sel <= 4'hF;
    wbc(1'b0, `PWMAUX_ADR_RA, 32'h0);
    check(rdat, 32'hF01);
    wbc(1'b1, `PWMAUX_ADR_RA, 32'h80);
    wbc(1'b1, `PWMAUX_ADR_RB, 32'hFF);
    wbc(1'b1, `PWMAUX_ADR_MASK, 32'h3);
    wbc(1'b1, `PWMAUX_ADR_CONF, 32'h29);
    wbc(1'b1, `PWMAUX_ADR_CTRL, 32'h1);
  endtask
  task automatic t_sel();
    for (int s = 0; s < 2; s++) begin
      wbc(1'b1, `PWMAUX_ADR_SYNC, (s != 0) ? 32'hCF : 32'h0F);
      repeat (300) begin
        @(negedge clk);
        check(wa, (s != 0) ? w1 : w0);
        check(wb, (s != 0) ? w0 : w1);
      end
    end
  endtask
  task automatic t_adc();
    for (int s = 0; s < 4; s++) begin
      wbc(1'b1, `PWMAUX_ADR_SYNC, 32'h0F | (s << 4));
      adc_win(2);
    end
    check(eirq, 1'b1);
    wbc(1'b1, `PWMAUX_ADR_CONF, 32'h28);
    adc_win(0);
    check(cirq, 1'b0);
    io_t <= 1'b1;
    adc_win(2);
    wbc(1'b1, `PWMAUX_ADR_CONF, 32'h0E29);
  endtask
  task automatic t_blank();
    wait_on();
    u_pwmaux_stage_model.set_fault(1'b1);
    repeat (6) @(negedge clk);
    repeat (40) begin
      @(negedge clk);
      check(w0, 1'b0);
    end
    check(cirq, 1'b1);
    adc_win(2);
    wbc(1'b0, `PWMAUX_ADR_CAPT, 32'h0);
    c1 = rdat;
    check(c1, 32'h4);
    u_pwmaux_stage_model.set_fault(1'b0);
    wait_on();
    repeat (20) @(negedge clk);
    u_pwmaux_stage_model.set_fault(1'b1);
    repeat (8) @(negedge clk);
    wbc(1'b0, `PWMAUX_ADR_CAPT, 32'h0);
    check(rdat, c1 + 32'd20);
    check(cirq, 1'b1);
    wbc(1'b1, `PWMAUX_ADR_FLAG, 32'h2);
    check(cirq, 1'b0);
  endtask
  task automatic t_chain();
    wbc(1'b1, `PWMAUX_ADR_CONF, 32'h0729);
    u_pwmaux_stage_model.set_fault(1'b0);
    wbc(1'b1, `PWMAUX_ADR_CTRL, 32'h2);
    run_prev <= 1'b1;
    repeat (2) @(negedge clk);
    check(run_nxt, 1'b1);
    @(posedge clk) run_prev <= 1'b0;
    @(negedge clk);
    check(run_nxt, 1'b0);
    @(posedge clk) run_prev <= 1'b1;
    @(posedge clk) fnext <= 1'b1;
    @(posedge clk) fnext <= 1'b0;
    @(negedge clk);
    check(run_nxt, 1'b0);
    @(posedge clk) run_prev <= 1'b0;
    @(posedge clk) run_prev <= 1'b1;
    f = 1'b0;
    repeat (300) begin
      @(negedge clk);
      f = f | cend;
    end
    check(f, 1'b1);
    check(cirq, 1'b1);
    u_pwmaux_stage_model.set_fault(1'b1);
    f = 1'b0;
    repeat (10) begin
      @(negedge clk);
      f = f | fprev;
    end
    check(f, 1'b1);
  endtask
  // Four-ramp matrix, polarity low: out0 on in ramp 0 only, out1 its inverse
  task automatic t_matrix();
    int n;
    n = 0;
    wbc(1'b1, `PWMAUX_ADR_MAT, 32'hE1);
    wbc(1'b1, `PWMAUX_ADR_CONF, 32'h15);
    wbc(1'b1, `PWMAUX_ADR_CTRL, 32'h1);
    repeat (4) @(negedge clk);
    repeat (1024) begin
      @(negedge clk);
      n += w0;
      check(w1, !w0);
    end
    check(n, 256);
  endtask
  initial begin
    {rst_n, cyc, stb, we, run_prev, io_t, fnext, adr, dat} = '0;
    sel = 4'hF;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_setup();
    t_sel();
    t_adc();
    t_blank();
    t_chain();
    t_matrix();
    stop_test();
  end
endmodule
`default_nettype wire

// [verif/pwmaux_stage_model.sv]
// Power stage and ADC stand-in: drives the fault pin, counts sync pulses
`default_nettype none
module pwmaux_stage_model (
  // Clock
  input  wire logic clk_i,
  // Device side
  input  wire logic adc_sync_i,
  output var  logic retrig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int adc_cnt = 0;
  initial retrig_o = 1'b0;
  // Pulses are counted, never held, so a stuck-high sync shows as excess
  always @(posedge clk_i) if (adc_sync_i === 1'b1) adc_cnt <= adc_cnt + 1;
  task automatic set_fault(input logic lvl);
    @(posedge clk_i) retrig_o <= lvl;
  endtask
endmodule
`default_nettype wire
